// ==== atc_pkg.sv ====
// Package of constants and types for the asynchronous timer clocking block
package atc_pkg;
  // ============================================================
  // Register byte offsets
  localparam logic [7:0] ATC_OFF_CNT  = 8'h00;
  localparam logic [7:0] ATC_OFF_CMP  = 8'h04;
  localparam logic [7:0] ATC_OFF_CTL  = 8'h08;
  localparam logic [7:0] ATC_OFF_ASR  = 8'h0C;
  localparam logic [7:0] ATC_OFF_GTC  = 8'h10;
  localparam logic [7:0] ATC_OFF_IEN  = 8'h14;
  localparam logic [7:0] ATC_OFF_FLG  = 8'h18;
  // ============================================================
  // Field positions
  localparam int ATC_CTL_CS_LSB    = 0;
  localparam int ATC_ASR_CTL_BUSY  = 0;
  localparam int ATC_ASR_CMP_BUSY  = 1;
  localparam int ATC_ASR_CNT_BUSY  = 2;
  localparam int ATC_ASR_EXTERNAL_CLOCK_SELECT     = 4;
  localparam int ATC_ASR_ASYNC     = 5;
  localparam int ATC_GTC_PSR       = 1;
  localparam int ATC_IEN_OVF       = 0;
  localparam int ATC_IEN_CMP       = 1;
  localparam int ATC_FLG_OVF       = 0;
  localparam int ATC_FLG_CMP       = 1;
  // ============================================================
  // Reset values
  localparam logic [7:0] ATC_RST_BYTE = 8'h00;
  // ============================================================
  // Clock select codes
  typedef enum logic [2:0] {
    ATC_CS_STOP = 3'h0, ATC_CS_DIV1 = 3'h1, ATC_CS_DIV8 = 3'h2, ATC_CS_DIV32 = 3'h3,
    ATC_CS_DIV64 = 3'h4, ATC_CS_DIV128 = 3'h5, ATC_CS_DIV256 = 3'h6, ATC_CS_DIV1024 = 3'h7
  } atc_cs_t;
  // Commit stages in oscillator edges
  localparam int ATC_COMMIT_EDGES = 2;
  // ============================================================
  // Holding register commit states
  typedef enum logic [1:0] {
    ATC_HS_IDLE = 2'b00, ATC_HS_EDGE1 = 2'b01, ATC_HS_EDGE2 = 2'b11
  } atc_hstate_t;
endpackage

// ==== atc_hold.sv ====
// Holding register with update-busy flag, committed on tick_edge strobes (oscillator edges in async mode, every I/O cycle otherwise)
`timescale 1ns/1ps
`default_nettype none
module atc_hold
  import atc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       tick_edge,
  output logic            busy_ff,
  output logic            commit_ff,
  output logic [7:0]      hold_ff
);
  atc_hstate_t st_ff;
  atc_hstate_t nxt_st;
  // ============================================================
  // Commit sequencing
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ATC_HS_IDLE: begin
        if (wr_en) nxt_st = ATC_HS_EDGE1;
      end
      ATC_HS_EDGE1: begin
        if (tick_edge) nxt_st = ATC_HS_EDGE2;
      end
      ATC_HS_EDGE2: begin
        if (tick_edge) nxt_st = ATC_HS_IDLE;
      end
      default: nxt_st = ATC_HS_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff     <= ATC_HS_IDLE;
      busy_ff   <= 1'b0;
      commit_ff <= 1'b0;
      hold_ff   <= ATC_RST_BYTE;
    end else begin
      st_ff     <= nxt_st;
      busy_ff   <= (nxt_st != ATC_HS_IDLE); // R4
      commit_ff <= (st_ff == ATC_HS_EDGE2) && tick_edge; // R2
      if (wr_en && st_ff == ATC_HS_IDLE) begin
        hold_ff <= wr_data; // R2
      end
    end
  end
  busy_clear_a: assert property (@(posedge mclk) disable iff (srst)
    commit_ff |-> !busy_ff) else $error("busy still set after commit"); // R4
  two_edges_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(busy_ff) |-> !commit_ff [*2]) else $error("commit too early"); // R2
endmodule
`default_nettype wire

// ==== atc_top.sv ====
// Timer clock selection, prescaler and asynchronous register crossing
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Synchronous timer tick is a clock enable on the I/O clock.
// R2: Writes to counter, compare, control go to holding; commit after two oscillator edges.
// R3: Each of those three registers has its own holding register.
// R4: One busy flag per holding register, cleared when committed.
// R5: Software must not rewrite a register while its write is pending.
// R6: CPU clock must exceed four times the oscillator frequency.
// R7: Software follows the safe clock-source switching sequence.
// R8: Compare match suppressed while compare or counter write is pending.
// R9: Software waits for updates to finish before sleep.
// R10: Interrupt logic needs one oscillator cycle to reset after wake-up.
// R11: Wake-up starts on the timer cycle after the interrupt condition.
// R12: Counter reads come from a copy refreshed on each oscillator edge.
// R13: Software writes compare or control, waits busy, then reads counter.
// R14: Interrupt flag crossing takes three CPU cycles plus one timer cycle.
// R15: Compare output changes on the timer clock, unsynchronised to CPU.
// R16: Source clock is I/O clock; async select takes oscillator pin.
// R17: Async select releases both oscillator pins from port function.
// R18: Software sets external clock select when pin is externally driven.
// R19: Oscillator keeps running in async mode except power-down and standby.
// R20: Register contents are lost after power-down or standby wake-up.
// R21: Prescaler gives 1, 8, 32, 64, 128, 256, 1024 and stop.
// R22: Prescaler reset bit restarts division from a known phase.
// R23: Clock select codes 000 stop, 001 undivided, then 8 to 1024.
// R24: Prescaler reset request is carried safely into the source domain.
module atc_top
  import atc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        osc_input_pin,
  input  wire logic        deep_sleep,
  output logic             osc_run,
  output logic             osc_pins_released,
  output logic             compare_output_a,
  output logic             wake_request,
  output logic             irq
);
  // ============================================================
  // Pin synchroniser and oscillator edge
  logic        osc_s1_ff, osc_s2_ff, osc_s3_ff;
  logic        async_clock_select_ff, external_clock_select_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= osc_input_pin;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end
  wire osc_edge = osc_s2_ff & ~osc_s3_ff;
  // Source clock enable: every I/O cycle, or each oscillator edge
  wire src_en = async_clock_select_ff ? osc_edge : 1'b1; // R16 R1
  // ============================================================
  // APB decode
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire hit_cnt = (paddr == ATC_OFF_CNT);
  wire hit_cmp = (paddr == ATC_OFF_CMP);
  wire hit_ctl = (paddr == ATC_OFF_CTL);
  wire hit_asr = (paddr == ATC_OFF_ASR);
  wire hit_gtc = (paddr == ATC_OFF_GTC);
  wire hit_ien = (paddr == ATC_OFF_IEN);
  wire hit_flg = (paddr == ATC_OFF_FLG);
  wire mapped  = hit_cnt | hit_cmp | hit_ctl | hit_asr | hit_gtc | hit_ien | hit_flg;
  // ============================================================
  // Holding registers
  logic       cnt_busy, cmp_busy, ctl_busy;
  logic       cnt_commit, cmp_commit, ctl_commit;
  logic [7:0] cnt_hold, cmp_hold, ctl_hold;
  // Synchronous mode commits after two I/O cycles
  wire hold_edge = async_clock_select_ff ? osc_edge : 1'b1;
  atc_hold u_cnt_hold ( // R3
    .mclk(mclk), .srst(srst), .wr_en(wr & hit_cnt), .wr_data(pwdata[7:0]),
    .tick_edge(hold_edge), .busy_ff(cnt_busy), .commit_ff(cnt_commit), .hold_ff(cnt_hold));
  atc_hold u_cmp_hold ( // R3
    .mclk(mclk), .srst(srst), .wr_en(wr & hit_cmp), .wr_data(pwdata[7:0]),
    .tick_edge(hold_edge), .busy_ff(cmp_busy), .commit_ff(cmp_commit), .hold_ff(cmp_hold));
  atc_hold u_ctl_hold ( // R3
    .mclk(mclk), .srst(srst), .wr_en(wr & hit_ctl), .wr_data(pwdata[7:0]),
    .tick_edge(hold_edge), .busy_ff(ctl_busy), .commit_ff(ctl_commit), .hold_ff(ctl_hold));
  // ============================================================
  // Destination registers
  logic [7:0] async_counter_ff, compare_value_a_ff, timer_control_a_ff, cnt_copy_ff;
  logic [1:0] irq_en_ff;
  logic       psr_req_ff, psr_s1_ff, psr_s2_ff;
  logic [9:0] presc_ff;
  logic       tick_ff;
  wire  [2:0] clock_select_field = timer_control_a_ff[ATC_CTL_CS_LSB +: 3];
  // ============================================================
  // Prescaler reset crossing into the source domain
  always_ff @(posedge mclk) begin
    if (srst) begin
      psr_req_ff <= 1'b0;
      psr_s1_ff  <= 1'b0;
      psr_s2_ff  <= 1'b0;
    end else begin
      if (wr & hit_gtc & pwdata[ATC_GTC_PSR]) psr_req_ff <= 1'b1;
      else if (psr_s2_ff) psr_req_ff <= 1'b0;
      if (src_en) psr_s1_ff <= psr_req_ff; // R24
      if (src_en) psr_s2_ff <= psr_s1_ff; // R24
    end
  end
  wire psr_pending = psr_req_ff | psr_s2_ff;
  // ============================================================
  // Prescaler and tick selection
  logic tick_sel;
  always_comb begin
    case (atc_cs_t'(clock_select_field)) // R23 R21
      ATC_CS_STOP:    tick_sel = 1'b0;
      ATC_CS_DIV1:    tick_sel = 1'b1;
      ATC_CS_DIV8:    tick_sel = (presc_ff[2:0] == 3'h7);
      ATC_CS_DIV32:   tick_sel = (presc_ff[4:0] == 5'h1F);
      ATC_CS_DIV64:   tick_sel = (presc_ff[5:0] == 6'h3F);
      ATC_CS_DIV128:  tick_sel = (presc_ff[6:0] == 7'h7F);
      ATC_CS_DIV256:  tick_sel = (presc_ff[7:0] == 8'hFF);
      ATC_CS_DIV1024: tick_sel = (presc_ff == 10'h3FF);
      default:        tick_sel = 1'b0;
    endcase
  end
  wire tick = src_en & tick_sel;
  always_ff @(posedge mclk) begin
    if (srst) begin
      presc_ff <= 10'h000;
      tick_ff  <= 1'b0;
    end else begin
      if (src_en && psr_s2_ff) presc_ff <= 10'h000; // R22
      else if (src_en) presc_ff <= presc_ff + 10'h001;
      tick_ff <= tick; // R1
    end
  end
  // ============================================================
  // Counter, compare and output
  wire match_block = cmp_busy | cnt_busy; // R8
  wire cmp_match   = tick & (async_counter_ff == compare_value_a_ff) & ~match_block; // R8
  logic ovf_raw_ff, cmp_raw_ff, osc_tick_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      async_counter_ff   <= ATC_RST_BYTE;
      compare_value_a_ff <= ATC_RST_BYTE;
      timer_control_a_ff <= ATC_RST_BYTE;
      compare_output_a   <= 1'b0;
      ovf_raw_ff         <= 1'b0;
      cmp_raw_ff         <= 1'b0;
    end else begin
      if (cnt_commit) async_counter_ff <= cnt_hold; // R2
      else if (tick) async_counter_ff <= async_counter_ff + 8'h01;
      if (cmp_commit) compare_value_a_ff <= cmp_hold; // R2
      if (ctl_commit) timer_control_a_ff <= ctl_hold; // R2
      if (cmp_match) compare_output_a <= ~compare_output_a; // R15
      ovf_raw_ff <= tick & (async_counter_ff == 8'hFF);
      cmp_raw_ff <= cmp_match;
    end
  end
  // ============================================================
  // Flag crossing: wait one timer cycle, then three CPU cycles
  logic [1:0] flg_wait_ff, flg_d1_ff, flg_d2_ff, flags_ff;
  wire  [1:0] raw = {cmp_raw_ff, ovf_raw_ff};
  wire  [1:0] flg_clr = (wr & hit_flg) ? pwdata[1:0] : 2'b00;
  always_ff @(posedge mclk) begin
    if (srst) begin
      flg_wait_ff <= 2'b00;
      flg_d1_ff   <= 2'b00;
      flg_d2_ff   <= 2'b00;
      flags_ff    <= 2'b00;
      osc_tick_ff <= 1'b0;
      cnt_copy_ff <= ATC_RST_BYTE;
    end else begin
      osc_tick_ff <= hold_edge;
      flg_wait_ff <= (flg_wait_ff & ~{2{osc_tick_ff}}) | raw; // R14
      flg_d1_ff   <= flg_wait_ff & {2{osc_tick_ff}}; // R14
      flg_d2_ff   <= flg_d1_ff; // R14
      flags_ff    <= (flags_ff & ~flg_clr) | flg_d2_ff; // R14
      if (src_en) cnt_copy_ff <= async_counter_ff; // R12
    end
  end
  // ============================================================
  // Wake-up one timer cycle after the condition; interrupt from the crossed flags
  logic wake_arm_ff;
  wire  pend_irq = |(flags_ff & irq_en_ff);
  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_arm_ff  <= 1'b0;
      wake_request <= 1'b0;
      irq          <= 1'b0;
    end else begin
      if (|(raw & irq_en_ff)) wake_arm_ff <= 1'b1;
      else if (hold_edge) wake_arm_ff <= 1'b0; // R10
      if (wake_arm_ff && hold_edge) wake_request <= 1'b1; // R11
      else if (!wake_arm_ff) wake_request <= 1'b0;
      irq <= pend_irq;
    end
  end
  // ============================================================
  // Status, mode and pin control
  always_ff @(posedge mclk) begin
    if (srst) begin
      async_clock_select_ff    <= 1'b0;
      external_clock_select_ff <= 1'b0;
      irq_en_ff                <= 2'b00;
      osc_run                  <= 1'b0;
      osc_pins_released        <= 1'b0;
    end else begin
      if (wr & hit_asr) begin
        async_clock_select_ff    <= pwdata[ATC_ASR_ASYNC]; // R16
        external_clock_select_ff <= pwdata[ATC_ASR_EXTERNAL_CLOCK_SELECT];
      end
      if (wr & hit_ien) irq_en_ff <= pwdata[1:0];
      osc_run           <= async_clock_select_ff & ~external_clock_select_ff & ~deep_sleep; // R19 R20
      osc_pins_released <= async_clock_select_ff; // R17
    end
  end
  // ============================================================
  // APB read and response
  wire [7:0] asr_rd = {2'b00, async_clock_select_ff, external_clock_select_ff, 1'b0,
                       cnt_busy, cmp_busy, ctl_busy};
  wire [7:0] rd_byte = hit_cnt ? (async_clock_select_ff ? cnt_copy_ff : async_counter_ff) :
                       hit_cmp ? compare_value_a_ff :
                       hit_ctl ? timer_control_a_ff :
                       hit_asr ? asr_rd :
                       hit_gtc ? {6'h00, psr_pending, 1'b0} :
                       hit_ien ? {6'h00, irq_en_ff} :
                       hit_flg ? {6'h00, flags_ff} : 8'h00;
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= {24'h00_0000, rd_byte};
    end
  end
  // ============================================================
  // Checks
  match_block_a: assert property (@(posedge mclk) disable iff (srst)
    (cmp_busy | cnt_busy) |-> ##1 !cmp_raw_ff) else $error("match while pending"); // R8
  flag_delay_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(flags_ff[0]) |-> $past(flg_d1_ff[0], 2)) else $error("flag crossing short"); // R14
  pins_follow_a: assert property (@(posedge mclk) disable iff (srst)
    async_clock_select_ff |=> osc_pins_released) else $error("pins not released"); // R17
  copy_track_a: assert property (@(posedge mclk) disable iff (srst)
    (async_clock_select_ff && osc_edge) |=> cnt_copy_ff == $past(async_counter_ff))
    else $error("counter copy stale"); // R12
  sync_tick_a: assert property (@(posedge mclk) disable iff (srst)
    (!async_clock_select_ff && clock_select_field == 3'h1) |-> src_en)
    else $error("tick not every cycle"); // R1
  stop_code_a: assert property (@(posedge mclk) disable iff (srst)
    (clock_select_field == 3'h0) |-> !tick) else $error("stopped timer ticked"); // R23
  presc_clr_a: assert property (@(posedge mclk) disable iff (srst)
    (src_en && psr_s2_ff) |=> presc_ff == 10'h000) else $error("prescaler not reset"); // R22
  wake_next_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(wake_request) |-> $past(wake_arm_ff)) else $error("wake without condition"); // R11
endmodule
`default_nettype wire

// ==== atc_osc_model.sv ====
// Crystal oscillator model driving the timer oscillator input pin
`timescale 1ns/1ps
`default_nettype none
module atc_osc_model #(
  parameter time HALF_NS  = 300ns,
  parameter time OFFSET_NS = 37ns
) (
  input  wire logic osc_run,
  output logic      osc_input_pin
);
  // ============================================================
  // Oscillation
  // Period of 12 CPU clocks keeps the CPU more than four times faster
  initial begin
    osc_input_pin = 1'b0;
    #OFFSET_NS;
    forever begin
      if (osc_run === 1'b1) begin
        #HALF_NS osc_input_pin = ~osc_input_pin;
      end else begin
        osc_input_pin = 1'b0;
        @(osc_run);
      end
    end
  end
endmodule
`default_nettype wire

// ==== test_async_timer_clock_crossing.sv ====
// Self-checking bench for the timer clock selection and crossing block
`timescale 1ns/1ps
`default_nettype none
module test_async_timer_clock_crossing;
  import atc_pkg::*;
  logic        mclk, srst, psel, penable, pwrite, deep_sleep;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, rd2;
  logic        pready, pslverr, osc_input_pin, osc_run, osc_pins_released;
  logic        compare_output_a, wake_request, irq, er, wake_seen;
  int          fail_count, comparisons, cyc, n;
  int          divs [3] = '{1, 8, 32};

  atc_top u_atc_top (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .osc_input_pin(osc_input_pin), .deep_sleep(deep_sleep),
    .osc_run(osc_run), .osc_pins_released(osc_pins_released),
    .compare_output_a(compare_output_a), .wake_request(wake_request), .irq(irq));
  atc_osc_model u_atc_osc_model (.osc_run(osc_run), .osc_input_pin(osc_input_pin));

  // ============================================================
  // Clock, timeout and reporting
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    if (wake_request === 1'b1) wake_seen <= 1'b1;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // ============================================================
  // APB master
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) chk(32'h0000_0000, 32'h0000_0001, "no ready");
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, ATC_OFF_ASR, 32'h0000_0000);
      k++;
    end while (rd[2:0] !== 3'b000 && k < 40);
    chk({31'h0, k < 40}, 32'h0000_0001, "busy flags stuck");
  endtask

  task automatic period_of(output int p);
    logic prev;
    int   k;
    prev = compare_output_a;
    k = 0;
    while (compare_output_a === prev && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    prev = compare_output_a;
    p = 0;
    while (compare_output_a === prev && p < 20000) begin
      @(posedge mclk);
      p++;
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset_and_map;
    chk({28'h0, pready, pslverr, irq, osc_run}, 32'h0000_0000, "outputs after reset");
    apb(1'b0, ATC_OFF_ASR, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "status reset value");
    apb(1'b0, ATC_OFF_CTL, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "control reset value");
    apb(1'b1, 8'h1C, 32'h0000_00FF);
    chk({31'h0, er}, 32'h0000_0001, "unmapped write error");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
  endtask

  task automatic t_sync_divisions;
    apb(1'b1, ATC_OFF_IEN, 32'h0000_0002);
    apb(1'b1, ATC_OFF_CMP, 32'h0000_0010);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ATC_OFF_CTL, 32'(i + 1));
      wait_idle();
      period_of(n);
      period_of(n);
      chk(32'(n), 32'(256 * divs[i]), "toggle period");
      apb(1'b0, ATC_OFF_FLG, 32'h0000_0000);
      chk({30'h0, rd[1], irq}, 32'h0000_0003, "compare flag and irq");
      chk({31'h0, wake_seen}, 32'h0000_0001, "wake request after match");
      wake_seen <= 1'b0;
      apb(1'b1, ATC_OFF_FLG, 32'h0000_0002);
      apb(1'b0, ATC_OFF_FLG, 32'h0000_0000);
      chk({30'h0, rd[1], irq}, 32'h0000_0000, "flag cleared");
    end
  endtask

  task automatic t_stop_and_prescaler;
    apb(1'b1, ATC_OFF_CTL, 32'h0000_0000);
    wait_idle();
    apb(1'b0, ATC_OFF_CNT, 32'h0000_0000);
    rd2 = rd;
    repeat (300) @(posedge mclk);
    apb(1'b0, ATC_OFF_CNT, 32'h0000_0000);
    chk(rd, rd2, "stopped counter moved");
    apb(1'b1, ATC_OFF_GTC, 32'h0000_0002);
    n = 0;
    do begin
      apb(1'b0, ATC_OFF_GTC, 32'h0000_0000);
      n++;
    end while (rd[ATC_GTC_PSR] !== 1'b0 && n < 30);
    chk({31'h0, n < 30}, 32'h0000_0001, "prescaler reset pending");
  endtask

  task automatic t_async_switch;
    apb(1'b1, ATC_OFF_IEN, 32'h0000_0000);
    apb(1'b1, ATC_OFF_ASR, 32'h0000_0020);
    repeat (2) @(posedge mclk);
    chk({30'h0, osc_run, osc_pins_released}, 32'h0000_0003, "async select");
    apb(1'b1, ATC_OFF_CNT, 32'h0000_0005);
    apb(1'b1, ATC_OFF_CMP, 32'h0000_0080);
    apb(1'b1, ATC_OFF_CTL, 32'h0000_0001);
    apb(1'b0, ATC_OFF_ASR, 32'h0000_0000);
    chk(rd, 32'h0000_0027, "three busy flags");
    wait_idle();
    apb(1'b1, ATC_OFF_FLG, 32'h0000_0003);
    apb(1'b0, ATC_OFF_CMP, 32'h0000_0000);
    chk(rd, 32'h0000_0080, "compare committed");
    apb(1'b0, ATC_OFF_CNT, 32'h0000_0000);
    rd2 = rd;
    repeat (48) @(posedge mclk);
    apb(1'b0, ATC_OFF_CNT, 32'h0000_0000);
    n = int'(rd[7:0] - rd2[7:0]);
    chk({31'h0, n >= 3 && n <= 5}, 32'h0000_0001, "synced counter advance");
    deep_sleep <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, osc_run}, 32'h0000_0000, "oscillator stops in deep sleep");
    deep_sleep <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, osc_run}, 32'h0000_0001, "oscillator restarts");
    apb(1'b1, ATC_OFF_ASR, 32'h0000_0030);
    repeat (2) @(posedge mclk);
    chk({30'h0, osc_run, osc_pins_released}, 32'h0000_0001, "external clock select");
  endtask

  // ============================================================
  // Main sequence
  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; deep_sleep = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    fail_count = 0; comparisons = 0; cyc = 0; wake_seen = 1'b0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    t_reset_and_map();
    t_sync_divisions();
    t_stop_and_prescaler();
    t_async_switch();
    finish_test();
  end
endmodule
`default_nettype wire
